/* logic/bus_port_params.svh */
`ifndef BUS_PORT_PARAMS_SVH
`define BUS_PORT_PARAMS_SVH
`define ADDR_MIN      5'h01
`define ADDR_MAX      5'h1f
`define CMD_GTL       8'h01
`define CMD_SDC       8'h04
`define CMD_LLO       8'h11
`define CMD_DCL       8'h14
`define CMD_SPE       8'h18
`define CMD_SPD       8'h19
`define GRP_LISTEN    3'h1
`define GRP_TALK      3'h2
`define CMD_UNL       8'h3f
`define CMD_UNT       8'h5f
`define CH_STAR       8'h2a
`define CH_QUERY      8'h3f
`define CH_SEMI       8'h3b
`define CH_CR         8'h0d
`define CH_LF         8'h0a
`define CH_SPACE      8'h20
`define MSG_MAX       8'hff
`define BUF_DEPTH     2
`endif

/* logic/bus_port_pkg.sv */
package bus_port_pkg;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_BODY = 2'b01,
        RX_CR   = 2'b10,
        RX_DROP = 2'b11
    } rx_state_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_POLL = 2'b01,
        TX_RESP = 2'b10
    } tx_state_t;
endpackage

/* logic/instrument_bus_remote_port.sv */
`timescale 1ns/1ps
`include "bus_port_params.svh"
module instrument_bus_remote_port
    import bus_port_pkg::*;
(
    input  wire logic       clk,            // 200 mhz clock
    input  wire logic       reset,          // async, active high
    input  wire logic [4:0] cfg_addr,       // front-panel bus address
    input  wire logic       cfg_addr_set,   // address has been configured
    input  wire logic       port_select,    // 1: this port is the remote interface
    input  wire logic       key_remote,     // remote/local key, one-cycle press
    input  wire logic       key_valid,      // keypad event
    input  wire logic [7:0] key_code,       // keypad code
    input  wire logic       ren,            // remote enable line, active high
    input  wire logic       ifc,            // interface clear line, active high
    input  wire logic       atn_n,          // attention, active low
    input  wire logic       rx_valid,       // byte from acceptor handshake
    input  wire logic [7:0] rx_data,        // received byte
    input  wire logic       rx_eoi,         // end flag with byte
    output logic            rx_ready,       // byte accepted
    input  wire logic       srq_req,        // status system wants service
    input  wire logic [7:0] status_byte,    // status byte for polling
    output logic            srq_o,          // service request drive
    output logic            srq_oe,         // service request enable
    output logic            remote_led,     // remote lamp
    output logic            lockout,        // front panel locked out
    output logic            keypad_valid,   // keypad event passed on
    output logic [7:0]      keypad_code,    // keypad code passed on
    output logic            cmd_valid,      // complete command ready
    output logic            cmd_common,     // command starts with asterisk
    output logic            cmd_query,      // command is a query
    output logic [7:0]      cmd_len,        // command length in characters
    output logic [7:0]      cmd_wr_data,    // command character
    output logic            cmd_wr,         // command character strobe
    output logic            dev_clear,      // device clear pulse
    input  wire logic       resp_valid,     // response character ready
    input  wire logic [7:0] resp_data,      // response character
    input  wire logic       resp_last,      // last response character
    output logic            resp_ready,     // response character taken
    input  wire logic       tx_ready,       // source handshake ready
    output logic            tx_valid,       // byte to source handshake
    output logic [7:0]      tx_data,        // byte to send
    output logic            tx_eoi          // end flag with byte
);

    // address decode shared by talk and listen groups
    function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] grp,
                                      input logic [4:0] a);
        addr_hit = (b[7:5] == grp) && (b[4:0] == a);
    endfunction

    logic       addr_ok;
    logic       ifc_q_r, ifc_q_nxt;
    // silent until a legal address is set
    assign addr_ok = cfg_addr_set && (cfg_addr >= `ADDR_MIN) && (cfg_addr <= `ADDR_MAX)
                     && port_select;

    // two-entry skid buffer on the receive path
    logic [8:0] buf_r [`BUF_DEPTH];
    logic [8:0] buf_nxt [`BUF_DEPTH];
    logic [1:0] cnt_r, cnt_nxt;
    logic       pop;
    logic [7:0] b_data;
    logic       b_eoi;
    logic       b_atn;
    logic [`BUF_DEPTH-1:0] atn_r, atn_nxt;

    assign b_data = buf_r[0][7:0];
    assign b_eoi  = buf_r[0][8];
    assign b_atn  = atn_r[0];

    // buffer next state; push and pop may share a cycle
    always_comb begin
        buf_nxt = buf_r;
        atn_nxt = atn_r;
        cnt_nxt = cnt_r;
        if (pop) begin
            buf_nxt[0] = buf_r[1];
            atn_nxt[0] = atn_r[1];
            cnt_nxt    = cnt_r - 2'h1;
        end
        if (rx_valid && rx_ready) begin
            buf_nxt[cnt_nxt[0]] = {rx_eoi, rx_data};
            atn_nxt[cnt_nxt[0]] = ~atn_n;
            cnt_nxt             = cnt_nxt + 2'h1;
        end
        if (ifc) begin
            cnt_nxt = 2'h0;
        end
    end

    // interface state
    logic remote_r, remote_nxt, llo_r, llo_nxt, lad_r, lad_nxt, tad_r, tad_nxt;
    logic spe_r, spe_nxt, clr_r, clr_nxt;
    // receive parser
    rx_state_t  rx_r, rx_nxt;
    logic [7:0] len_r, len_nxt;
    logic       star_r, star_nxt, qry_r, qry_nxt, sp_r, sp_nxt;
    logic       cv_r, cv_nxt, cc_r, cc_nxt, cq_r, cq_nxt;
    logic [7:0] cl_r, cl_nxt, cwd_r, cwd_nxt;
    logic       cw_r, cw_nxt;
    logic       pend_r, pend_nxt;
    logic       kv_r, kv_nxt;
    logic [7:0] kc_r, kc_nxt;

    // consume one buffered byte each cycle
    assign pop = (cnt_r != 2'h0) && !ifc;

    // bus commands, addressing, remote/local and the character parser
    always_comb begin
        remote_nxt = remote_r;
        llo_nxt    = llo_r;
        lad_nxt    = lad_r;
        tad_nxt    = tad_r;
        spe_nxt    = spe_r;
        clr_nxt    = 1'b0;
        rx_nxt     = rx_r;
        len_nxt    = len_r;
        star_nxt   = star_r;
        qry_nxt    = qry_r;
        sp_nxt     = sp_r;
        cv_nxt     = 1'b0;
        cc_nxt     = cc_r;
        cq_nxt     = cq_r;
        cl_nxt     = cl_r;
        cw_nxt     = 1'b0;
        cwd_nxt    = cwd_r;
        pend_nxt   = pend_r;
        if (key_remote && !llo_r) begin
            remote_nxt = ~remote_r;
        end
        if (ren && addr_ok && !remote_r) begin
            remote_nxt = 1'b1;
        end
        if (!ren) begin
            llo_nxt = 1'b0;
        end
        if (pop && addr_ok && b_atn) begin
            if (addr_hit(b_data, `GRP_LISTEN, cfg_addr)) begin
                lad_nxt = 1'b1;
                tad_nxt = 1'b0; // unaddressed to talk when told to listen
            end else if (addr_hit(b_data, `GRP_TALK, cfg_addr)) begin
                tad_nxt = 1'b1;
                lad_nxt = 1'b0;
            end else if (b_data[7:5] == `GRP_TALK) begin
                tad_nxt = 1'b0; // another talker takes the bus
            end
            if (b_data == `CMD_UNL) begin
                lad_nxt = 1'b0;
            end
            if (b_data == `CMD_UNT) begin
                tad_nxt = 1'b0;
            end
            if (b_data == `CMD_LLO) begin
                llo_nxt = 1'b1;
            end
            if (b_data == `CMD_SPE) begin
                spe_nxt = 1'b1;
            end
            if (b_data == `CMD_SPD) begin
                spe_nxt = 1'b0;
            end
            if ((b_data == `CMD_DCL) || ((b_data == `CMD_SDC) && lad_r)) begin
                clr_nxt = 1'b1;
                rx_nxt  = RX_IDLE;
                pend_nxt = 1'b0;
            end
            if ((b_data == `CMD_GTL) && lad_r) begin
                remote_nxt = 1'b0;
            end
        end else if (pop && addr_ok && lad_r) begin
            // device data only while addressed to listen
            cw_nxt  = (b_data != `CH_SEMI) && (b_data != `CH_CR) && (b_data != `CH_LF);
            cwd_nxt = b_data;
            unique case (rx_r)
                RX_IDLE, RX_BODY: begin
                    if (rx_r == RX_IDLE) begin
                        star_nxt = (b_data == `CH_STAR);
                        qry_nxt  = 1'b0;
                        sp_nxt   = 1'b0;
                        len_nxt  = 8'h00;
                    end
                    if (b_data == `CH_CR) begin
                        rx_nxt = RX_CR;
                    end else if ((b_data == `CH_SEMI) || b_eoi) begin
                        // separator or end flag closes one command
                        cv_nxt  = 1'b1;
                        cc_nxt  = star_nxt;
                        cq_nxt  = qry_nxt;
                        cl_nxt  = len_nxt + ((b_data == `CH_SEMI) ? 8'h00 : 8'h01);
                        rx_nxt  = RX_IDLE;
                        if (qry_nxt) begin
                            pend_nxt = 1'b1;
                        end
                    end else if (len_nxt == `MSG_MAX) begin
                        rx_nxt = RX_DROP; // over-length
                    end else begin
                        len_nxt = len_nxt + 8'h01;
                        rx_nxt  = RX_BODY;
                        if (b_data == `CH_SPACE) begin
                            sp_nxt = 1'b1;
                        end else if (!sp_nxt) begin
                            qry_nxt = (b_data == `CH_QUERY); // mnemonic tail
                        end
                    end
                end
                RX_CR: begin
                    if (b_data == `CH_LF) begin
                        cv_nxt = 1'b1;
                        cc_nxt = star_r;
                        cq_nxt = qry_r;
                        cl_nxt = len_r;
                        pend_nxt = qry_r ? 1'b1 : pend_r;
                    end
                    rx_nxt = RX_IDLE;
                end
                RX_DROP: begin
                    if ((b_data == `CH_LF) || b_eoi) begin
                        rx_nxt = RX_IDLE;
                    end
                end
            endcase
        end
        if (ifc) begin
            lad_nxt = 1'b0;
            tad_nxt = 1'b0;
            spe_nxt = 1'b0;
            rx_nxt  = RX_IDLE;
        end
    end

    // keypad gating in remote or lockout
    always_comb begin
        kv_nxt = key_valid && !remote_r && !llo_r;
        kc_nxt = key_code;
    end

    // talker: poll byte or prepared response
    tx_state_t  tx_r, tx_nxt;
    logic       tv_r, tv_nxt, te_r, te_nxt, rr_r, rr_nxt;
    logic [7:0] td_r, td_nxt;
    logic       talk_ok;
    assign talk_ok = tad_r && atn_n && addr_ok && !ifc;

    always_comb begin
        tx_nxt = tx_r;
        tv_nxt = tv_r;
        td_nxt = td_r;
        te_nxt = te_r;
        rr_nxt = 1'b0;
        if (tv_r && tx_ready) begin
            tv_nxt = 1'b0;
        end
        unique case (tx_r)
            TX_IDLE: begin
                if (talk_ok && spe_r && !tv_r) begin
                    tx_nxt = TX_POLL;
                    tv_nxt = 1'b1;
                    td_nxt = status_byte;
                    te_nxt = 1'b0;
                end else if (talk_ok && pend_r && resp_valid && !tv_r && !rr_r) begin
                    tx_nxt = TX_RESP;
                end
            end
            TX_POLL: begin
                if (!spe_r || !talk_ok) begin
                    tx_nxt = TX_IDLE;
                end
            end
            TX_RESP: begin
                if (!talk_ok) begin
                    tx_nxt = TX_IDLE;
                    tv_nxt = 1'b0;
                end else if (!tv_nxt && resp_valid && !rr_r) begin
                    tv_nxt = 1'b1;
                    td_nxt = resp_data;
                    te_nxt = resp_last;
                    rr_nxt = 1'b1;
                    if (resp_last) begin
                        tx_nxt = TX_IDLE;
                    end
                end
            end
            default: tx_nxt = TX_IDLE;
        endcase
        if (ifc) begin
            tv_nxt = 1'b0;
        end
    end

    logic pend_fin;
    // response consumed clears pending, a new query wins over the clear
    assign pend_fin = (rr_r && te_r && !(cv_nxt && cq_nxt)) ? 1'b0 : pend_nxt;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            buf_r    <= '{default: 9'h000};
            atn_r    <= '0;
            cnt_r    <= 2'h0;
            remote_r <= 1'b0;
            llo_r    <= 1'b0;
            lad_r    <= 1'b0;
            tad_r    <= 1'b0;
            spe_r    <= 1'b0;
            clr_r    <= 1'b0;
            rx_r     <= RX_IDLE;
            len_r    <= 8'h00;
            star_r   <= 1'b0;
            qry_r    <= 1'b0;
            sp_r     <= 1'b0;
            cv_r     <= 1'b0;
            cc_r     <= 1'b0;
            cq_r     <= 1'b0;
            cl_r     <= 8'h00;
            cw_r     <= 1'b0;
            cwd_r    <= 8'h00;
            pend_r   <= 1'b0;
            kv_r     <= 1'b0;
            kc_r     <= 8'h00;
            tx_r     <= TX_IDLE;
            tv_r     <= 1'b0;
            td_r     <= 8'h00;
            te_r     <= 1'b0;
            rr_r     <= 1'b0;
            rx_ready <= 1'b0;
            srq_o    <= 1'b0;
            srq_oe   <= 1'b0;
        end else begin
            buf_r    <= buf_nxt;
            atn_r    <= atn_nxt;
            cnt_r    <= cnt_nxt;
            remote_r <= remote_nxt;
            llo_r    <= llo_nxt;
            lad_r    <= lad_nxt;
            tad_r    <= tad_nxt;
            spe_r    <= spe_nxt;
            clr_r    <= clr_nxt;
            rx_r     <= rx_nxt;
            len_r    <= len_nxt;
            star_r   <= star_nxt;
            qry_r    <= qry_nxt;
            sp_r     <= sp_nxt;
            cv_r     <= cv_nxt;
            cc_r     <= cc_nxt;
            cq_r     <= cq_nxt;
            cl_r     <= cl_nxt;
            cw_r     <= cw_nxt;
            cwd_r    <= cwd_nxt;
            pend_r   <= pend_fin;
            kv_r     <= kv_nxt;
            kc_r     <= kc_nxt;
            tx_r     <= tx_nxt;
            tv_r     <= tv_nxt;
            td_r     <= td_nxt;
            te_r     <= te_nxt;
            rr_r     <= rr_nxt;
            // ready only with a free slot after this cycle's pop
            rx_ready <= (cnt_nxt < 2'h2) && !(rx_valid && rx_ready && cnt_nxt == 2'h1);
            srq_o    <= 1'b0; // pull low when enabled, open collector
            srq_oe   <= srq_req && addr_ok;
        end
    end

    assign remote_led   = remote_r;
    assign lockout      = llo_r;
    assign keypad_valid = kv_r;
    assign keypad_code  = kc_r;
    assign cmd_valid    = cv_r;
    assign cmd_common   = cc_r;
    assign cmd_query    = cq_r;
    assign cmd_len      = cl_r;
    assign cmd_wr       = cw_r;
    assign cmd_wr_data  = cwd_r;
    assign dev_clear    = clr_r;
    assign resp_ready   = rr_r;
    assign tx_valid     = tv_r;
    assign tx_data      = td_r;
    assign tx_eoi       = te_r;

endmodule

/* bench/bus_port_assertions.sv */
`timescale 1ns/1ps
`include "bus_port_params.svh"
module bus_port_checker (
    input wire logic       clk,          // clock
    input wire logic       reset,        // async reset
    input wire logic [4:0] cfg_addr,     // bus address
    input wire logic       cfg_addr_set, // address set
    input wire logic       port_select,  // port active
    input wire logic       key_valid,    // keypad event
    input wire logic [7:0] key_code,     // keypad code
    input wire logic       ren,          // remote enable
    input wire logic       ifc,          // interface clear
    input wire logic       atn_n,        // attention
    input wire logic       rx_valid,     // byte offered
    input wire logic [7:0] rx_data,      // byte in
    input wire logic       rx_ready,     // byte taken
    input wire logic       srq_req,      // wants service
    input wire logic       srq_o,        // srq drive
    input wire logic       srq_oe,       // srq enable
    input wire logic       remote_led,   // remote lamp
    input wire logic       lockout,      // panel locked
    input wire logic       keypad_valid, // keypad out
    input wire logic [7:0] keypad_code,  // keypad code out
    input wire logic       cmd_wr,       // char strobe
    input wire logic [7:0] cmd_wr_data,  // char
    input wire logic       dev_clear,    // clear pulse
    input wire logic       tx_valid      // byte out
);
    logic ok;
    // usable address: set, port chosen and nonzero
    assign ok = cfg_addr_set && port_select && (cfg_addr != 5'h00);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // command byte taken under attention
    sequence take_cmd(logic [7:0] code);
        rx_valid && rx_ready && !atn_n && rx_data == code && ok;
    endsequence
    srq_quiet_a: assert property (srq_o == 1'b0)
        else $error("srq driven high");
    srq_follow_a: assert property (srq_oe == ($past(srq_req && ok) && !$past(reset)))
        else $error("srq enable wrong");
    key_block_a: assert property (keypad_valid |-> $past(key_valid && !remote_led && !lockout)
        && keypad_code == $past(key_code)) else $error("keypad passed wrongly");
    ren_remote_a: assert property ($rose(ren) && ok |-> ##[1:3] remote_led)
        else $error("ren did not set remote");
    lockout_set_a: assert property (take_cmd(`CMD_LLO) ##0 ren ##1 ren[*3] |-> lockout)
        else $error("lockout not set");
    clear_pulse_a: assert property (take_cmd(`CMD_DCL) |-> ##[1:3] dev_clear)
        else $error("device clear missing");
    ifc_abort_a: assert property (ifc |-> ##[1:2] !tx_valid)
        else $error("transfer kept after ifc");
    cmd_char_a: assert property (cmd_wr |-> !(cmd_wr_data inside {`CH_SEMI, `CH_CR, `CH_LF}))
        else $error("separator passed as char");
endmodule
bind instrument_bus_remote_port bus_port_checker i_bus_port_checker (.*);

/* bench/bus_controller_model.sv */
`timescale 1ns/1ps
module bus_controller_model (
    input  wire logic       clk,      // clock
    input  wire logic       rx_ready, // device took byte
    input  wire logic [1:0] mode,     // 0 ready, 1 slow, 2 hold
    output logic            atn_n,    // attention
    output logic            rx_valid, // byte offered
    output logic [7:0]      rx_data,  // byte lines
    output logic            rx_eoi,   // end flag
    output logic            tx_ready  // controller listening
);
    logic [1:0] beat = 2'h0;
    initial begin
        atn_n = 1'b1;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_eoi = 1'b0;
        tx_ready = 1'b0;
    end
    // slow mode listens two cycles in four, so the talker must hold
    always @(negedge clk) begin
        beat <= beat + 2'h1;
        tx_ready <= (mode == 2'h0) || (mode == 2'h1 && beat[1]);
    end
    // byte held until taken at a rising edge
    task automatic send(input logic cmd_n, input logic [7:0] b, input logic last);
        @(negedge clk);
        atn_n = cmd_n;
        rx_valid = 1'b1;
        rx_data = b;
        rx_eoi = last;
        @(posedge clk iff rx_ready);
    endtask
    // released lines do not keep the last byte
    task automatic idle();
        @(negedge clk);
        atn_n = 1'b1;
        rx_valid = 1'b0;
        rx_eoi = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule

/* bench/instrument_bus_remote_port_bench.sv */
`timescale 1ns/1ps
`include "bus_port_params.svh"
module instrument_bus_remote_port_bench;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [4:0]  cfg_addr = 5'h00;
    logic        cfg_addr_set = 1'b0, port_select = 1'b0, srq_req = 1'b0;
    logic        key_remote = 1'b0, key_valid = 1'b0, ren = 1'b0, ifc = 1'b0;
    logic [7:0]  key_code = 8'h00, status_byte = 8'h00, resp_data = 8'h00;
    logic        resp_valid = 1'b0, resp_last = 1'b0;
    logic        atn_n, rx_valid, rx_eoi, rx_ready, tx_ready, tx_valid, tx_eoi;
    logic        srq_o, srq_oe, remote_led, lockout, keypad_valid, dev_clear;
    logic        cmd_valid, cmd_common, cmd_query, cmd_wr, resp_ready;
    logic [7:0]  rx_data, tx_data, keypad_code, cmd_len, cmd_wr_data;
    logic [1:0]  mode = 2'h0;
    logic [4:0]  a;
    logic [9:0]  e;
    logic [31:0] rng = 32'h8ce5ac50;
    logic [7:0]  exp_chr[$], exp_key[$], resp_q[$];
    logic [9:0]  exp_cmd[$], exp_tx[$];
    int          errors = 0, cmp_count = 0, clr_seen = 0;

    instrument_bus_remote_port i_instrument_bus_remote_port (.*);
    bus_controller_model i_bus_controller_model (.*);

    always #2.5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic cmp(input logic [9:0] got, input logic [9:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic extra(input string what);
        errors++;
        $display("[ERR] %0t unexpected %s", $time, what);
    endtask

    task automatic end_sim();
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic bus(input logic [7:0] b);
        i_bus_controller_model.send(1'b0, b, 1'b0);
        i_bus_controller_model.idle();
    endtask

    // model splits at semicolons; terminator is crlf or end flag
    task automatic msg(input string s, input logic eoi, input logic heard);
        string c;
        int n;
        int st;
        st = 0;
        for (int i = 0; i <= s.len(); i++) begin
            if (i == s.len() || s[i] == `CH_SEMI) begin
                c = "";
                if (i > st) c = s.substr(st, i - 1);
                if (heard && c.len() > 0) begin
                    n = 0;
                    while (n < c.len() && c[n] != `CH_SPACE) n++;
                    exp_cmd.push_back({c[0] == `CH_STAR, c[n-1] == `CH_QUERY, 8'(c.len())});
                end
                st = i + 1;
            end else if (heard) begin
                exp_chr.push_back(s[i]);
            end
        end
        // messages stay far below the length limit
        for (int i = 0; i < s.len(); i++)
            i_bus_controller_model.send(1'b1, s[i], eoi && i == s.len() - 1);
        if (!eoi) begin
            i_bus_controller_model.send(1'b1, `CH_CR, 1'b0);
            i_bus_controller_model.send(1'b1, `CH_LF, 1'b0);
        end
        i_bus_controller_model.idle();
    endtask

    task automatic key(input logic rem, input logic [7:0] c);
        @(negedge clk);
        key_remote = rem;
        key_valid = !rem;
        key_code = c;
        @(negedge clk);
        key_remote = 1'b0;
        key_valid = 1'b0;
        tick(4);
    endtask

    task automatic drain();
        for (int i = 0; i < 200 && exp_tx.size() != 0; i++) tick(1);
    endtask

    // characters, commands, tx bytes and keys against the model; clears counted
    always @(posedge clk) begin
        if (!reset) begin
            if (cmd_wr) begin
                if (exp_chr.size() == 0) extra("char");
                else cmp({2'b00, cmd_wr_data}, {2'b00, exp_chr.pop_front()}, "char");
            end
            if (cmd_valid) begin
                if (exp_cmd.size() == 0) extra("command");
                else cmp({cmd_common, cmd_query, cmd_len}, exp_cmd.pop_front(), "cmd");
            end
            if (tx_valid && tx_ready) begin
                if (exp_tx.size() == 0) extra("tx byte");
                else begin
                    e = exp_tx.pop_front();
                    cmp({e[9], tx_eoi, tx_data}, e, "tx");
                end
            end
            if (keypad_valid) begin
                if (exp_key.size() == 0) extra("key");
                else cmp({2'b00, keypad_code}, {2'b00, exp_key.pop_front()}, "key");
            end
            if (dev_clear) clr_seen++;
            if (resp_valid && resp_ready) void'(resp_q.pop_front());
        end
    end

    // response source shows the queue head
    always @(negedge clk) begin
        resp_valid <= resp_q.size() != 0;
        resp_data <= resp_q.size() != 0 ? resp_q[0] : 8'h00;
        resp_last <= resp_q.size() == 1;
    end

    initial begin
        tick(10);
        reset = 1'b0;
        rng = xs(rng);
        a = (rng[4:0] == 5'h00) ? 5'h1f : rng[4:0];
        // silent with address unset, port off, or address zero
        for (int k = 0; k < 3; k++) begin
            cfg_addr_set = (k != 0);
            port_select = (k != 1);
            cfg_addr = (k == 2) ? 5'h00 : a;
            srq_req = 1'b1;
            bus({`GRP_LISTEN, cfg_addr});
            msg("X?", 1'b0, 1'b0);
        end
        cfg_addr_set = 1'b1;
        port_select = 1'b1;
        cfg_addr = a;
        srq_req = rng[5];
        bus({`GRP_LISTEN, a});
        msg("*IDN?;SETP 1,2.5", 1'b0, 1'b1);
        msg("RANGE? 1", 1'b1, 1'b1);
        bus(`CMD_UNL);
        msg("X 1", 1'b0, 1'b0);
        // two queries, then talk: one response, nothing before
        bus({`GRP_LISTEN, a});
        msg("A?;B?", 1'b0, 1'b1);
        resp_q = '{8'h34, 8'h32};
        tick(20);
        exp_tx = '{10'h234, 10'h332};
        mode = 2'h1;
        bus({`GRP_TALK, a});
        drain();
        bus(`CMD_UNT);
        resp_q = '{8'h39};
        bus({`GRP_TALK, a});
        tick(30);
        resp_q.delete();
        // serial poll returns the status byte
        rng = xs(rng);
        status_byte = rng[7:0];
        bus(`CMD_UNT);
        bus(`CMD_SPE);
        exp_tx.push_back({2'b00, rng[7:0]});
        bus({`GRP_TALK, a});
        drain();
        bus(`CMD_SPD);
        // interface clear while a poll byte is stalled
        mode = 2'h2;
        bus(`CMD_UNT);
        bus(`CMD_SPE);
        bus({`GRP_TALK, a});
        for (int i = 0; i < 40 && tx_valid !== 1'b1; i++) tick(1);
        cmp({9'h0, tx_valid}, 10'h1, "poll offered");
        ifc = 1'b1;
        tick(1);
        ifc = 1'b0;
        tick(3);
        mode = 2'h0;
        tick(20);
        cmp({9'h0, tx_valid}, 10'h0, "after ifc");
        bus(`CMD_SPD);
        // clears: universal, unaddressed selective, addressed selective
        bus(`CMD_DCL);
        bus(`CMD_UNL);
        bus(`CMD_SDC);
        bus({`GRP_LISTEN, a});
        bus(`CMD_SDC);
        tick(5);
        cmp(10'(clr_seen), 10'h2, "clears");
        // remote, lockout, go to local, key toggling
        ren = 1'b1;
        tick(5);
        cmp({9'h0, remote_led}, 10'h1, "remote");
        bus(`CMD_LLO);
        tick(5);
        cmp({9'h0, lockout}, 10'h1, "lockout");
        key(1'b1, 8'h00);
        key(1'b0, rng[15:8]);
        cmp({9'h0, remote_led}, 10'h1, "key locked");
        ren = 1'b0;
        bus(`CMD_GTL);
        tick(5);
        cmp({8'h0, remote_led, lockout}, 10'h0, "local");
        exp_key.push_back(rng[23:16]);
        key(1'b0, rng[23:16]);
        key(1'b1, 8'h00);
        cmp({9'h0, remote_led}, 10'h1, "toggle on");
        key(1'b0, rng[31:24]);
        key(1'b1, 8'h00);
        cmp({9'h0, remote_led}, 10'h0, "toggle off");
        tick(10);
        cmp(10'(exp_chr.size() + exp_cmd.size() + exp_tx.size() + exp_key.size()), 10'h0, "left");
        end_sim();
    end

    // watchdog: the sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        extra("timeout");
        end_sim();
    end
endmodule
